/* hdl/jtisp_pkg.sv */
// Constants, instruction codes and TAP state encoding for the JTAG/ISP I/O block
package jtisp_pkg;
    localparam int IR_W = 10;
    localparam int ID_W = 32;
    localparam int ID_VER_W = 4;
    localparam int ID_PART_W = 16;
    localparam int ID_MFR_W = 11;
    localparam logic ID_LSB = 1'b1;
    // Instruction codes
    localparam logic [IR_W-1:0] INS_BYPASS = 10'h3ff;
    localparam logic [IR_W-1:0] INS_IDCODE = 10'h006;
    localparam logic [IR_W-1:0] INS_USER_A = 10'h00c;
    localparam logic [IR_W-1:0] INS_USER_B = 10'h00e;
    localparam logic [IR_W-1:0] INS_ISP_ENTER = 10'h2cc;
    localparam logic [IR_W-1:0] INS_ISP_EXIT = 10'h201;
    localparam logic [IR_W-1:0] INS_CLAMP = 10'h0cf;
    localparam logic [IR_W-1:0] INS_PROG_CFG = 10'h2f2;
    localparam logic [IR_W-1:0] INS_PROG_UFM = 10'h2f3;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    // Per-pin clamp codes
    localparam int CLAMP_W = 2;
    localparam logic [1:0] CLAMP_HOLD = 2'h0;
    localparam logic [1:0] CLAMP_HIGH = 2'h1;
    localparam logic [1:0] CLAMP_LOW = 2'h2;
    localparam logic [1:0] CLAMP_TRI = 2'h3;
    typedef enum logic [3:0] {
        TS_RESET = 4'b1111,
        TS_IDLE = 4'b1100,
        TS_SEL_DR = 4'b0111,
        TS_CAP_DR = 4'b0110,
        TS_SH_DR = 4'b0010,
        TS_EX1_DR = 4'b0001,
        TS_PAU_DR = 4'b0011,
        TS_EX2_DR = 4'b0000,
        TS_UPD_DR = 4'b0101,
        TS_SEL_IR = 4'b0100,
        TS_CAP_IR = 4'b1110,
        TS_SH_IR = 4'b1010,
        TS_EX1_IR = 4'b1001,
        TS_PAU_IR = 4'b1011,
        TS_EX2_IR = 4'b1000,
        TS_UPD_IR = 4'b1101
    } jtisp_tstate_t;
endpackage

/* hdl/jtisp_tap_if.sv */
// TAP state and edge carrier between the controller and the core
`timescale 1ns/100ps
interface jtisp_tap_if;
    import jtisp_pkg::*;
    jtisp_tstate_t state;
    logic [IR_W-1:0] ir;
    logic ir_lsb;
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    modport ctrl (output state, output ir, output ir_lsb, output rise, output fall,
        output tms, output tdi);
    modport core (input state, input ir, input ir_lsb, input rise, input fall,
        input tms, input tdi);
endinterface

/* hdl/jtisp_tap.sv */
// TAP controller: finds test-clock edges, walks the state machine, holds the IR
`timescale 1ns/100ps
module jtisp_tap
    import jtisp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Synchronised test pins
    input wire logic tck_s,
    input wire logic tms_s,
    input wire logic tdi_s,
    // Core side
    jtisp_tap_if.ctrl tap
);
    typedef struct packed {
        jtisp_tstate_t state;
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic tck_prev;
    } jtisp_tap_st_t;

    jtisp_tap_st_t s_q, s_d;
    logic rise, fall;

    // Edges are seen in the same clock that the synchronised level moves
    assign rise = tck_s & ~s_q.tck_prev;
    assign fall = ~tck_s & s_q.tck_prev;
    assign tap.state = s_q.state;
    assign tap.ir = s_q.ir;
    assign tap.ir_lsb = s_q.ir_sh[0];
    assign tap.rise = rise;
    assign tap.fall = fall;
    assign tap.tms = tms_s;
    assign tap.tdi = tdi_s;

    // State walk and IR path on each rising test-clock edge
    always_comb
    begin
        s_d = s_q;
        s_d.tck_prev = tck_s;
        if (rise)
        begin
            unique case (s_q.state)
                TS_RESET: s_d.state = tms_s ? TS_RESET : TS_IDLE;
                TS_IDLE: s_d.state = tms_s ? TS_SEL_DR : TS_IDLE;
                TS_SEL_DR: s_d.state = tms_s ? TS_SEL_IR : TS_CAP_DR;
                TS_CAP_DR: s_d.state = tms_s ? TS_EX1_DR : TS_SH_DR;
                TS_SH_DR: s_d.state = tms_s ? TS_EX1_DR : TS_SH_DR;
                TS_EX1_DR: s_d.state = tms_s ? TS_UPD_DR : TS_PAU_DR;
                TS_PAU_DR: s_d.state = tms_s ? TS_EX2_DR : TS_PAU_DR;
                TS_EX2_DR: s_d.state = tms_s ? TS_UPD_DR : TS_SH_DR;
                TS_UPD_DR: s_d.state = tms_s ? TS_SEL_DR : TS_IDLE;
                TS_SEL_IR: s_d.state = tms_s ? TS_RESET : TS_CAP_IR;
                TS_CAP_IR: s_d.state = tms_s ? TS_EX1_IR : TS_SH_IR;
                TS_SH_IR: s_d.state = tms_s ? TS_EX1_IR : TS_SH_IR;
                TS_EX1_IR: s_d.state = tms_s ? TS_UPD_IR : TS_PAU_IR;
                TS_PAU_IR: s_d.state = tms_s ? TS_EX2_IR : TS_PAU_IR;
                TS_EX2_IR: s_d.state = tms_s ? TS_UPD_IR : TS_SH_IR;
                TS_UPD_IR: s_d.state = tms_s ? TS_SEL_DR : TS_IDLE;
            endcase
            unique case (s_q.state)
                TS_RESET: s_d.ir = INS_IDCODE;
                TS_CAP_IR: s_d.ir_sh = {{(IR_W-2){1'b0}}, IR_CAPTURE};
                TS_SH_IR: s_d.ir_sh = {tdi_s, s_q.ir_sh[IR_W-1:1]};
                TS_UPD_IR: s_d.ir = s_q.ir_sh;
                default: s_d.ir = s_q.ir;
            endcase
        end
    end

    // Apart from tck_prev, which follows every enabled clock, only the test-clock edge moves this state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{state: TS_RESET, ir_sh: '0, ir: INS_IDCODE, tck_prev: 1'b0};
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end
endmodule // jtisp_tap

/* hdl/jtisp_top.sv */
// Top of the JTAG block: ID word, user chains, ISP pin clamp and power-up output gating
`timescale 1ns/100ps
module jtisp_top
    import jtisp_pkg::*;
#(
    parameter int NPIN = 8,
    parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h1, // Arbitrary value
    parameter logic [ID_PART_W-1:0] ID_PART = 16'h1234, // Arbitrary value
    parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h055 // Arbitrary value
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Test access pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Supply and configuration status, asynchronous
    input wire logic vccint_ok,
    input wire logic vccio_ok,
    input wire logic config_done,
    // User logic pin drive
    input wire logic [NPIN-1:0] user_o,
    input wire logic [NPIN-1:0] user_oe,
    // I/O pin buffers
    output logic [NPIN-1:0] pin_o,
    output logic [NPIN-1:0] pin_oe,
    output logic [NPIN-1:0] pin_pullup,
    // User scan chains
    input wire logic user_tdo_a,
    input wire logic user_tdo_b,
    output logic user_chain_a_instr,
    output logic user_chain_b_instr,
    output logic user_tck,
    output logic user_tms,
    output logic user_tdi,
    output logic [3:0] user_tap_state,
    // Flash region select and supply status
    output logic cfg_prog_en,
    output logic ufm_prog_en,
    output logic supply_low_output_kill
);
    localparam int CL_W = CLAMP_W * NPIN;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] pwr1;
        logic [2:0] pwr2;
        logic [ID_W-1:0] id_sh;
        logic [CL_W-1:0] cl_sh;
        logic [CL_W-1:0] cl_code;
        logic [NPIN-1:0] hold_o;
        logic [NPIN-1:0] hold_oe;
        logic cl_armed;
        logic byp;
        logic isp;
        logic cfg_en;
        logic ufm_en;
        logic tdo;
        logic tdo_oe;
        logic ua;
        logic ub;
        logic utck;
        logic utms;
        logic utdi;
        logic [3:0] ustate;
        logic kill;
        logic [NPIN-1:0] po;
        logic [NPIN-1:0] poe;
        logic [NPIN-1:0] ppu;
    } jtisp_st_t;

    jtisp_st_t s_q, s_d;
    jtisp_tap_if tap();
    logic [ID_W-1:0] id_word;
    logic [NPIN-1:0] nx_o, nx_oe, nx_pu;
    logic out_ok, ir_a, ir_b;

    // TAP walker fed from the second synchroniser stage
    jtisp_tap u_tap (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tck_s(s_q.sync2[2]),
        .tms_s(s_q.sync2[1]),
        .tdi_s(s_q.sync2[0]),
        .tap(tap)
    );

    assign id_word = {ID_VERSION, ID_PART, ID_MFR, ID_LSB};
    assign ir_a = (tap.ir == INS_USER_A);
    assign ir_b = (tap.ir == INS_USER_B);
    // Outputs only once both supplies are good and configuration is complete
    assign out_ok = s_q.pwr2[2] & s_q.pwr2[1] & s_q.pwr2[0];

    // Per-pin drive selection: user, default ISP tri-state, or clamp
    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_pin
            logic [1:0] code;
            assign code = s_q.cl_code[CLAMP_W*i +: CLAMP_W];
            always_comb
            begin
                nx_o[i] = user_o[i];
                nx_oe[i] = user_oe[i];
                nx_pu[i] = 1'b0;
                if (s_q.isp && !s_q.cl_armed)
                begin
                    nx_o[i] = 1'b0;
                    nx_oe[i] = 1'b0;
                    nx_pu[i] = 1'b1;
                end
                else if (s_q.isp)
                begin
                    unique case (code)
                        CLAMP_HOLD:
                        begin
                            nx_o[i] = s_q.hold_o[i];
                            nx_oe[i] = s_q.hold_oe[i];
                        end
                        CLAMP_HIGH:
                        begin
                            nx_o[i] = 1'b1;
                            nx_oe[i] = 1'b1;
                        end
                        CLAMP_LOW:
                        begin
                            nx_o[i] = 1'b0;
                            nx_oe[i] = 1'b1;
                        end
                        CLAMP_TRI:
                        begin
                            nx_o[i] = 1'b0;
                            nx_oe[i] = 1'b0;
                        end
                    endcase
                end
                // Gate sits last so no mode can drive during a supply dip
                if (!out_ok)
                begin
                    nx_oe[i] = 1'b0;
                end
            end
        end
    endgenerate

    // Scan paths, ISP mode tracking and pin drive registers
    always_comb
    begin
        s_d = s_q;
        s_d.sync1 = {tck, tms, tdi};
        s_d.sync2 = s_q.sync1;
        s_d.pwr1 = {vccint_ok, vccio_ok, config_done};
        s_d.pwr2 = s_q.pwr1;
        s_d.kill = ~(s_q.pwr2[2] & s_q.pwr2[1]);
        s_d.po = nx_o;
        s_d.poe = nx_oe;
        s_d.ppu = nx_pu;
        // Mirror TAP activity to user logic only under a user instruction
        s_d.ua = ir_a;
        s_d.ub = ir_b;
        s_d.utck = (ir_a | ir_b) & s_q.sync2[2];
        s_d.utms = (ir_a | ir_b) & tap.tms;
        s_d.utdi = (ir_a | ir_b) & tap.tdi;
        s_d.ustate = (ir_a | ir_b) ? tap.state : TS_RESET;
        if (tap.rise)
        begin
            unique case (tap.state)
                TS_CAP_DR:
                begin
                    s_d.id_sh = id_word;
                    s_d.cl_sh = s_q.cl_code;
                    s_d.byp = 1'b0;
                    if (tap.ir == INS_CLAMP)
                    begin
                        // Only a driven pin is held; an input keeps oe low
                        s_d.hold_o = user_o & user_oe;
                        s_d.hold_oe = user_oe;
                    end
                end
                TS_SH_DR:
                begin
                    s_d.id_sh = {tap.tdi, s_q.id_sh[ID_W-1:1]};
                    s_d.cl_sh = {tap.tdi, s_q.cl_sh[CL_W-1:1]};
                    s_d.byp = tap.tdi;
                end
                TS_UPD_DR:
                begin
                    if (tap.ir == INS_CLAMP && !s_q.isp)
                    begin
                        s_d.cl_code = s_q.cl_sh;
                        s_d.cl_armed = 1'b1;
                    end
                end
                TS_IDLE:
                begin
                    // IR holds the new code only after Update-IR, so entry waits for idle
                    if (tap.ir == INS_ISP_ENTER)
                    begin
                        s_d.isp = 1'b1;
                    end
                end
                TS_RESET:
                begin
                    s_d.isp = 1'b0;
                    s_d.cl_armed = 1'b0;
                end
                default:
                begin
                    s_d.byp = s_q.byp;
                end
            endcase
        end
        // Leaving ISP releases tri-state and clamp together
        if (tap.rise && tap.state == TS_IDLE && tap.ir == INS_ISP_EXIT)
        begin
            s_d.isp = 1'b0;
            s_d.cl_armed = 1'b0;
        end
        // One flash region at a time; the other keeps its contents
        s_d.cfg_en = s_q.isp & (tap.ir == INS_PROG_CFG);
        s_d.ufm_en = s_q.isp & (tap.ir == INS_PROG_UFM);
        if (tap.fall)
        begin
            s_d.tdo_oe = (tap.state == TS_SH_DR) | (tap.state == TS_SH_IR);
            if (tap.state == TS_SH_IR)
            begin
                s_d.tdo = tap.ir_lsb;
            end
            else if (ir_a)
            begin
                s_d.tdo = user_tdo_a;
            end
            else if (ir_b)
            begin
                s_d.tdo = user_tdo_b;
            end
            else if (tap.ir == INS_IDCODE)
            begin
                s_d.tdo = s_q.id_sh[0];
            end
            else if (tap.ir == INS_CLAMP)
            begin
                s_d.tdo = s_q.cl_sh[0];
            end
            else
            begin
                s_d.tdo = s_q.byp;
            end
        end
    end

    // Reset leaves every pin undriven, as at power-up
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.kill <= 1'b1;
            s_q.ustate <= TS_RESET;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign tdo = s_q.tdo;
    assign tdo_oe = s_q.tdo_oe;
    assign pin_o = s_q.po;
    assign pin_oe = s_q.poe;
    assign pin_pullup = s_q.ppu;
    assign user_chain_a_instr = s_q.ua;
    assign user_chain_b_instr = s_q.ub;
    assign user_tck = s_q.utck;
    assign user_tms = s_q.utms;
    assign user_tdi = s_q.utdi;
    assign user_tap_state = s_q.ustate;
    assign cfg_prog_en = s_q.cfg_en;
    assign ufm_prog_en = s_q.ufm_en;
    assign supply_low_output_kill = s_q.kill;
endmodule // jtisp_top

/* verification/jtisp_top_sva.sv */
// Port-level checker for the JTAG/ISP I/O block
`timescale 1ns/100ps
module jtisp_top_sva
    import jtisp_pkg::*;
#(
    parameter int NPIN = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Test pins and status
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic vccint_ok,
    input wire logic vccio_ok,
    input wire logic config_done,
    input wire logic [NPIN-1:0] pin_oe,
    // User chain, flash and supply outputs
    input wire logic user_chain_a_instr,
    input wire logic user_chain_b_instr,
    input wire logic user_tck,
    input wire logic user_tms,
    input wire logic user_tdi,
    input wire logic [3:0] user_tap_state,
    input wire logic cfg_prog_en,
    input wire logic ufm_prog_en,
    input wire logic supply_low_output_kill
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Either user instruction counts as user mode
    wire any_user = user_chain_a_instr || user_chain_b_instr;
    // Four cycles cover the two-stage synchroniser plus the output register
    kill_on_a: assert property (!(vccint_ok && vccio_ok) [*4] |-> supply_low_output_kill)
        else $error("kill flag missing after supply loss");
    kill_off_a: assert property ((vccint_ok && vccio_ok) [*4] |-> !supply_low_output_kill)
        else $error("kill flag stuck with supplies good");
    kill_gate_a: assert property (supply_low_output_kill [*2] |-> pin_oe == '0)
        else $error("pin driven while supply low");
    cfg_gate_a: assert property (!config_done [*4] |-> pin_oe == '0)
        else $error("pin driven before configuration done");
    chain_mutex_a: assert property (!(user_chain_a_instr && user_chain_b_instr))
        else $error("both user chains selected");
    flash_mutex_a: assert property (!(cfg_prog_en && ufm_prog_en))
        else $error("both flash regions selected");
    state_hidden_a: assert property (!any_user && !$past(any_user)
        |-> user_tap_state == 4'hf && !user_tck)
        else $error("tap state exposed without user instruction");
    user_tdi_a: assert property (($stable(tdi) && any_user) [*6] |-> user_tdi == tdi)
        else $error("user tdi does not follow test data input");
    user_tck_a: assert property (($stable(tck) && any_user) [*6] |-> user_tck == tck)
        else $error("user tck does not follow test clock");
    user_tms_a: assert property (($stable(tms) && any_user) [*6] |-> user_tms == tms)
        else $error("user tms does not follow test mode select");
    tdo_fall_a: assert property ($changed(tdo) |-> $past(tck, 3) == 1'b0)
        else $error("tdo moved away from a test clock fall");
    // Main scenarios
    user_mode_c: cover property (user_chain_b_instr);
    cfg_prog_c: cover property (cfg_prog_en);
    kill_rise_c: cover property ($rose(supply_low_output_kill));
endmodule // jtisp_top_sva

bind jtisp_top jtisp_top_sva #(.NPIN(NPIN)) u_sva (.clk(clk), .rst(rst), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .vccint_ok(vccint_ok), .vccio_ok(vccio_ok),
    .config_done(config_done), .pin_oe(pin_oe), .user_chain_a_instr(user_chain_a_instr),
    .user_chain_b_instr(user_chain_b_instr), .user_tck(user_tck), .user_tms(user_tms),
    .user_tdi(user_tdi),
    .user_tap_state(user_tap_state), .cfg_prog_en(cfg_prog_en), .ufm_prog_en(ufm_prog_en),
    .supply_low_output_kill(supply_low_output_kill));

/* verification/jtisp_host_model.sv */
// Behavioural external test controller driving the test access pins
`timescale 1ns/100ps
module jtisp_host_model
(
    // Pacing clock
    input wire logic clk,
    // Test access pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // Test clock parked low outside frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 160 ns test clock; tdo read late in the high phase, as it lags the fall
    task automatic step(input logic m, input logic dv, output logic o);
        tms = m;
        tdi = dv;
        tck = 1'b0;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        o = tdo;
    endtask
    // Park low; tdi flips so a stale level never looks valid
    task automatic park();
        tck = 1'b0;
        tdi = ~tdi;
        repeat (4) @(negedge clk);
    endtask
    // Five ones reach Test-Logic-Reset, then one zero to Run-Test/Idle
    task automatic reset_tap();
        logic o;
        for (int i = 0; i < 6; i++)
            step(i < 5, tdi, o);
        park();
    endtask
    // Instruction or data scan from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, tdi, o);
        if (ir)
            step(1'b1, tdi, o);
        step(1'b0, tdi, o);
        step(1'b0, tdi, o);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, tdi, o);
        step(1'b0, tdi, o);
        step(1'b0, tdi, o); // Extra idle rise lets a pending exit take effect
        park();
    endtask
endmodule // jtisp_host_model

/* verification/jtag_isp_io_control_test.sv */
// Self-checking testbench for the JTAG/ISP I/O block
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module jtag_isp_io_control_test import jtisp_pkg::*;;
    logic clk, rst, ce, tck, tms, tdi, tdo, tdo_oe, vccint_ok, vccio_ok, config_done;
    logic user_tdo_a, user_tdo_b, user_chain_a_instr, user_chain_b_instr;
    logic user_tck, user_tms, user_tdi, cfg_prog_en, ufm_prog_en, supply_low_output_kill;
    logic [7:0] user_o, user_oe, pin_o, pin_oe, pin_pullup;
    logic [3:0] user_tap_state;
    logic [31:0] d;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Identity fields of the bench build, so the expected word is known here
    localparam logic [ID_VER_W-1:0] EXP_VER = 4'h3; // Arbitrary value
    localparam logic [ID_PART_W-1:0] EXP_PART = 16'h5a0f; // Arbitrary value
    localparam logic [ID_MFR_W-1:0] EXP_MFR = 11'h0b3; // Arbitrary value
    // Device under test and the external controller
    jtisp_top #(.NPIN(8), .ID_VERSION(EXP_VER), .ID_PART(EXP_PART), .ID_MFR(EXP_MFR))
        u_dut (.clk(clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .vccint_ok(vccint_ok), .vccio_ok(vccio_ok),
        .config_done(config_done), .user_o(user_o), .user_oe(user_oe), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .user_tdo_a(user_tdo_a),
        .user_tdo_b(user_tdo_b), .user_chain_a_instr(user_chain_a_instr),
        .user_chain_b_instr(user_chain_b_instr), .user_tck(user_tck), .user_tms(user_tms),
        .user_tdi(user_tdi), .user_tap_state(user_tap_state), .cfg_prog_en(cfg_prog_en),
        .ufm_prog_en(ufm_prog_en), .supply_low_output_kill(supply_low_output_kill));
    jtisp_host_model u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    // Verdict and end of run
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            stop_test();
        end
    end
    // Power-up gating, supply loss and configuration status
    task automatic power_check();
        repeat (6) @(negedge clk);
        `CHK(pin_oe, 8'h00)
        `CHK(supply_low_output_kill, 1'b1)
        vccint_ok = 1'b1;
        vccio_ok = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(supply_low_output_kill, 1'b0)
        `CHK(pin_oe, 8'h00)
        config_done = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(pin_oe, 8'h0f)
        `CHK(pin_o & pin_oe, 8'h05)
        vccio_ok = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(supply_low_output_kill, 1'b1)
        `CHK(pin_oe, 8'h00)
        vccio_ok = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(pin_oe, 8'h0f)
    endtask
    // Identification word and instruction capture pattern
    task automatic idcode_check();
        u_host.reset_tap();
        // Watch tdo_oe early in the shift, then after it
        fork
            u_host.scan(1'b0, 32, 32'h0, d);
            begin
                repeat (44) @(negedge clk);
                `CHK(tdo_oe, 1'b1)
            end
        join
        `CHK(tdo_oe, 1'b0)
        `CHK(d, {EXP_VER, EXP_PART, EXP_MFR, 1'b1})
        `CHK(d[0], 1'b1)
        u_host.scan(1'b1, IR_W, 32'(INS_IDCODE), d);
        `CHK(d[1:0], IR_CAPTURE)
    endtask
    // Each user instruction selects its own chain and exposes the TAP
    task automatic user_chain_check();
        for (int k = 0; k < 2; k++)
        begin
            user_tdo_a = (k == 0);
            user_tdo_b = (k == 1);
            u_host.scan(1'b1, IR_W, 32'((k == 0) ? INS_USER_A : INS_USER_B), d);
            `CHK({user_chain_a_instr, user_chain_b_instr}, (k == 0) ? 2'b10 : 2'b01)
            repeat (6) @(negedge clk);
            `CHK(user_tap_state, 4'(TS_IDLE))
            `CHK(user_tdi, tdi)
            u_host.scan(1'b0, 8, 32'h5a, d);
            `CHK(d[7:0], 8'hff)
        end
        // Outside user mode the one-bit bypass path answers, not the user chain
        u_host.scan(1'b1, IR_W, 32'(INS_BYPASS), d);
        u_host.scan(1'b0, 8, 32'h5a, d);
        `CHK(d[7:0], 8'hb4)
        u_host.scan(1'b1, IR_W, 32'(INS_IDCODE), d);
        repeat (3) @(negedge clk);
        `CHK(user_tap_state, 4'hf)
    endtask
    // Default programming entry, flash region selects and exit
    task automatic isp_check();
        u_host.scan(1'b1, IR_W, 32'(INS_ISP_ENTER), d);
        repeat (3) @(negedge clk);
        `CHK(pin_oe, 8'h00)
        `CHK(pin_pullup, 8'hff)
        u_host.scan(1'b1, IR_W, 32'(INS_PROG_CFG), d);
        `CHK({cfg_prog_en, ufm_prog_en}, 2'b10)
        u_host.scan(1'b1, IR_W, 32'(INS_PROG_UFM), d);
        `CHK({cfg_prog_en, ufm_prog_en}, 2'b01)
        u_host.scan(1'b1, IR_W, 32'(INS_ISP_EXIT), d);
        repeat (3) @(negedge clk);
        `CHK(pin_oe, 8'h0f)
        `CHK(pin_pullup, 8'h00)
        u_host.scan(1'b1, IR_W, 32'(INS_PROG_CFG), d);
        `CHK(cfg_prog_en, 1'b0)
    endtask
    // Per-pin clamp: hold, high, low, tri on pins 0-3 and again on 4-7
    task automatic clamp_check();
        u_host.scan(1'b1, IR_W, 32'(INS_CLAMP), d);
        u_host.scan(1'b0, 16, 32'he4e4, d);
        u_host.scan(1'b1, IR_W, 32'(INS_ISP_ENTER), d);
        repeat (3) @(negedge clk);
        `CHK(pin_oe, 8'h67)
        `CHK(pin_o & pin_oe, 8'h23)
        user_o = 8'h00;
        repeat (3) @(negedge clk);
        `CHK(pin_o & pin_oe, 8'h23)
        u_host.reset_tap();
        repeat (3) @(negedge clk);
        `CHK(pin_oe, 8'h0f)
        user_o = 8'h05;
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        vccint_ok = 1'b0;
        vccio_ok = 1'b0;
        config_done = 1'b0;
        user_o = 8'h05;
        user_oe = 8'h0f;
        user_tdo_a = 1'b0;
        user_tdo_b = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        power_check();
        idcode_check();
        user_chain_check();
        isp_check();
        clamp_check();
        stop_test();
    end
endmodule // jtag_isp_io_control_test
